// ===== hw/bcm_monitor.sv
/*
 * breaker clearing time monitor: times the mechanism after our own trip
 * pulse, flags a slow mechanism, keeps trip history and self-test health.
 * assumes trip pulse, buttons, currents and zero flags come from logic on
 * clk_in; the limit switch and the fault lines are pins and get synchronised.
 */
// How it works
// - timer starts on our trip pulse
// - only own trips are timed
// - above 33 ms sets slow alarm
// - alarm shown only after display request
// - zero method: one time per pole
// - limit method: switch change, one time
// - slow trip may latch segregated relay
// - alarm clears only on clear command
// - next: next alarm, else main view
// - keep eight latest trips, drop oldest
// - record holds currents and time stamp
// - review latest first, previous steps back
// - clear history erases all records
// - background tests drop health output
// - six fault sources count as internal
`timescale 1ns/1ps
`default_nettype none
module bcm_monitor #(
	parameter int unsigned TICK_CYC = bcm_pkg::TICK_CYC
) (
	input  wire logic             clk_in,
	input  wire logic             resetn_in,
	input  wire logic             trip_pulse_in,
	input  wire logic             method_limit_in,
	input  wire logic [2:0]       pole_zero_in,
	input  wire logic             limit_sw_in,
	input  wire logic [4:0][15:0] cur_in,
	input  wire logic [31:0]      stamp_in,
	input  wire logic             fv_on_slow_in,
	input  wire logic             relay_release_in,
	input  wire logic             display_req_in,
	input  wire logic             clear_alarm_in,
	input  wire logic             next_in,
	input  wire logic             other_alarm_in,
	input  wire logic             review_in,
	input  wire logic             prev_in,
	input  wire logic             exit_in,
	input  wire logic             clear_hist_in,
	input  wire logic [5:0]       fault_in,
	output logic                  segregated_trip_relay_out,
	output logic                  slow_alarm_out,
	output logic [1:0]            view_out,
	output logic                  timing_out,
	output logic [4:0][15:0]      rec_cur_out,
	output logic [31:0]           rec_stamp_out,
	output logic [2:0][15:0]      rec_time_out,
	output logic [2:0]            rec_ofs_out,
	output logic [3:0]            hist_count_out,
	output logic                  hist_busy_out,
	output logic                  health_ok_out
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [6:0] sync1_q;
	logic [6:0] sync2_q;
	logic       lim_s;
	logic [5:0] fault_s;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			sync1_q <= 7'h00;
			sync2_q <= 7'h00;
		end else begin
			sync1_q <= {limit_sw_in, fault_in};
			sync2_q <= sync1_q;
		end
	end
	assign lim_s   = sync2_q[6];
	assign fault_s = sync2_q[5:0];

	// ----------------------------------------------------------------
	// clearing timer
	// ----------------------------------------------------------------
	bcm_hist_if hist ();

	bcm_pkg::bcm_tstate_e st_q;
	logic [15:0]          tick_cnt_q;
	logic [15:0]          elapsed_q;
	logic [2:0]           done_q;
	logic [2:0][15:0]     ptime_q;
	logic                 lim_ref_q;
	logic [4:0][15:0]     cap_cur_q;
	logic [31:0]          cap_stamp_q;
	logic                 tick;
	logic                 timeout;
	logic                 lim_moved;
	logic                 start;
	logic                 slow_now;
	logic                 slow_evt;

	assign tick      = tick_cnt_q == 16'(TICK_CYC - 1);
	assign timeout   = elapsed_q == bcm_pkg::TIME_MAX;
	assign lim_moved = lim_s != lim_ref_q;
	// only our own pulse opens a measurement
	assign start     = st_q == bcm_pkg::TM_IDLE && trip_pulse_in;
	assign slow_now  = (ptime_q[0] > bcm_pkg::SLOW_LIMIT_TICKS) ||
	                   (ptime_q[1] > bcm_pkg::SLOW_LIMIT_TICKS) ||
	                   (ptime_q[2] > bcm_pkg::SLOW_LIMIT_TICKS);
	assign slow_evt  = hist.wr && slow_now;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			st_q       <= bcm_pkg::TM_IDLE;
			tick_cnt_q <= bcm_pkg::CNT_RESET;
			elapsed_q  <= bcm_pkg::CNT_RESET;
			done_q     <= 3'h0;
			ptime_q    <= '0;
			lim_ref_q  <= 1'b0;
		end else begin
			case (st_q)
				bcm_pkg::TM_IDLE: begin
					// timer starts with the trip pulse
					if (start) begin
						st_q       <= bcm_pkg::TM_TIMING;
						tick_cnt_q <= bcm_pkg::CNT_RESET;
						elapsed_q  <= bcm_pkg::CNT_RESET;
						done_q     <= 3'h0;
						ptime_q    <= '0;
						lim_ref_q  <= lim_s;
					end
				end
				bcm_pkg::TM_TIMING: begin
					tick_cnt_q <= tick ? bcm_pkg::CNT_RESET : 16'(tick_cnt_q + 16'h1);
					if (tick && !timeout)
						elapsed_q <= 16'(elapsed_q + 16'h1);
					if (timeout) begin
						// a stuck mechanism still yields a record, saturated
						for (int i = 0; i < 3; i++) begin
							if (!done_q[i])
								ptime_q[i] <= elapsed_q;
						end
						done_q <= 3'h7;
					end else if (method_limit_in) begin
						if (lim_moved && done_q != 3'h7) begin
							ptime_q[0] <= elapsed_q;
							done_q     <= 3'h7;
						end
					end else begin
						// each pole stops on its zero
						for (int i = 0; i < 3; i++) begin
							if (!done_q[i] && pole_zero_in[i]) begin
								ptime_q[i] <= elapsed_q;
								done_q[i]  <= 1'b1;
							end
						end
					end
					if (done_q == 3'h7)
						st_q <= bcm_pkg::TM_STORE;
				end
				bcm_pkg::TM_STORE: begin
					if (!hist.busy)
						st_q <= bcm_pkg::TM_IDLE;
				end
				default: st_q <= bcm_pkg::TM_IDLE;
			endcase
		end
	end

	// currents and stamp caught at the trip
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			cap_cur_q   <= '0;
			cap_stamp_q <= 32'h0000_0000;
		end else if (start) begin
			cap_cur_q   <= cur_in;
			cap_stamp_q <= stamp_in;
		end
	end

	// times travel inside the trip record
	assign hist.wr    = st_q == bcm_pkg::TM_STORE && !hist.busy;
	assign hist.wdata = '{cur: cap_cur_q, stamp: cap_stamp_q, ctime: ptime_q};

	bcm_trip_store #(.DEPTH(bcm_pkg::NREC)) u_store (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.hist      (hist)
	);

	// ----------------------------------------------------------------
	// alarm, relay and operator views
	// ----------------------------------------------------------------
	bcm_pkg::bcm_view_e view_q;
	logic               alarm_q;
	logic               relay_q;
	logic [2:0]         ofs_q;
	logic               clr_alarm;
	logic               can_prev;

	assign clr_alarm  = view_q == bcm_pkg::VW_ALARM && clear_alarm_in;
	assign can_prev   = 4'(ofs_q) + 4'h1 < hist.count;
	assign hist.clr   = view_q == bcm_pkg::VW_MAIN && clear_hist_in && !hist.busy;
	assign hist.rd_ofs = ofs_q;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			alarm_q <= 1'b0;
			relay_q <= 1'b0;
		end else begin
			// set wins, clear only by command
			alarm_q <= slow_evt || (alarm_q && !clr_alarm);
			// latching relay on a slow trip when enabled
			relay_q <= (slow_evt && fv_on_slow_in) || (relay_q && !relay_release_in);
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			view_q <= bcm_pkg::VW_MAIN;
			ofs_q  <= 3'h0;
		end else if (display_req_in) begin
			view_q <= alarm_q ? bcm_pkg::VW_ALARM : bcm_pkg::VW_MAIN;
		end else begin
			case (view_q)
				bcm_pkg::VW_ALARM: begin
					if (next_in || clr_alarm)
						view_q <= other_alarm_in ? bcm_pkg::VW_OTHER : bcm_pkg::VW_MAIN;
				end
				bcm_pkg::VW_OTHER: begin
					if (next_in)
						view_q <= bcm_pkg::VW_MAIN;
				end
				bcm_pkg::VW_MAIN: begin
					// review opens on the latest trip
					if (review_in && hist.count != 4'h0) begin
						view_q <= bcm_pkg::VW_HIST;
						ofs_q  <= 3'h0;
					end
				end
				bcm_pkg::VW_HIST: begin
					if (exit_in || hist.busy)
						view_q <= bcm_pkg::VW_MAIN;
					else if (prev_in && can_prev)
						ofs_q <= 3'(ofs_q + 3'h1);
				end
				default: view_q <= bcm_pkg::VW_MAIN;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			segregated_trip_relay_out <= 1'b0;
			slow_alarm_out            <= 1'b0;
			view_out                  <= bcm_pkg::VW_MAIN;
			timing_out                <= 1'b0;
			rec_cur_out               <= '0;
			rec_stamp_out             <= 32'h0000_0000;
			rec_time_out              <= '0;
			rec_ofs_out               <= 3'h0;
			hist_count_out            <= 4'h0;
			hist_busy_out             <= 1'b0;
			health_ok_out             <= 1'b0;
		end else begin
			segregated_trip_relay_out <= relay_q;
			slow_alarm_out            <= alarm_q && view_q == bcm_pkg::VW_ALARM;
			view_out                  <= view_q;
			timing_out                <= st_q == bcm_pkg::TM_TIMING;
			rec_cur_out               <= hist.rdata.cur;
			rec_stamp_out             <= hist.rdata.stamp;
			rec_time_out              <= hist.rdata.ctime;
			rec_ofs_out               <= ofs_q;
			hist_count_out            <= hist.count;
			hist_busy_out             <= hist.busy;
			// any of six faults drops health
			health_ok_out             <= fault_s == 6'h00;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	trip_starts_timer_a: assert property (start |=> st_q == bcm_pkg::TM_TIMING && elapsed_q == 16'h0)
		else $error("timer did not start on trip pulse");
	no_foreign_start_a: assert property (st_q == bcm_pkg::TM_IDLE && !trip_pulse_in |=> st_q == bcm_pkg::TM_IDLE)
		else $error("timer started without own trip");
	slow_sets_alarm_a: assert property (hist.wr && ptime_q[0] > bcm_pkg::SLOW_LIMIT_TICKS |=> alarm_q)
		else $error("slow mechanism not flagged");
	fast_no_alarm_a: assert property (hist.wr && !alarm_q && ptime_q[0] <= bcm_pkg::SLOW_LIMIT_TICKS &&
		ptime_q[1] <= bcm_pkg::SLOW_LIMIT_TICKS && ptime_q[2] <= bcm_pkg::SLOW_LIMIT_TICKS |=> !alarm_q)
		else $error("alarm set on a fast trip");
	alarm_on_request_a: assert property ($rose(view_q == bcm_pkg::VW_ALARM) |-> $past(display_req_in))
		else $error("alarm view opened without display request");
	pole_zero_stop_a: assert property (st_q == bcm_pkg::TM_TIMING && !method_limit_in && !done_q[1] &&
		pole_zero_in[1] |=> done_q[1] && ptime_q[1] == $past(elapsed_q))
		else $error("pole time not captured at zero");
	limit_single_time_a: assert property (st_q == bcm_pkg::TM_TIMING && method_limit_in && !timeout &&
		done_q == 3'h0 && lim_moved |=> done_q == 3'h7 && ptime_q[1] == 16'h0 ##1 st_q == bcm_pkg::TM_STORE)
		else $error("limit switch stop wrong");
	relay_latch_a: assert property (slow_evt && fv_on_slow_in |=> relay_q ##1 segregated_trip_relay_out)
		else $error("segregated relay not latched");
	alarm_hold_a: assert property (alarm_q && !clr_alarm |=> alarm_q)
		else $error("alarm cleared without command");
	next_view_a: assert property (view_q == bcm_pkg::VW_ALARM && next_in && !display_req_in && !other_alarm_in
		|=> view_q == bcm_pkg::VW_MAIN)
		else $error("next did not return to main");
	prev_step_a: assert property (view_q == bcm_pkg::VW_HIST && prev_in && can_prev && !exit_in &&
		!display_req_in && !hist.busy |=> ofs_q == 3'($past(ofs_q) + 3'h1))
		else $error("previous did not step back");
	health_drop_a: assert property (fault_in != 6'h00 |-> ##3 !health_ok_out)
		else $error("health stayed on with a fault");
endmodule : bcm_monitor
`default_nettype wire

// ===== hw/bcm_trip_store.sv
/*
 * ring of the most recent trip records, held in flip-flops.
 * assumes writes and clears come as one-cycle pulses from the monitor.
 */
`timescale 1ns/1ps
`default_nettype none
module bcm_trip_store #(
	parameter int unsigned DEPTH = bcm_pkg::NREC
) (
	input  wire logic    clk_in,
	input  wire logic    resetn_in,
	bcm_hist_if.store    hist
);
	bcm_pkg::bcm_rec_s mem_q [DEPTH];
	logic [2:0]        wp_q;
	logic [3:0]        count_q;
	logic              busy_q;
	logic [2:0]        ci_q;
	logic [2:0]        rd_idx;

	// newest record sits just behind the write pointer
	assign rd_idx     = 3'(wp_q - 3'h1 - hist.rd_ofs);
	assign hist.rdata = mem_q[rd_idx];
	assign hist.busy  = busy_q;
	assign hist.count = count_q;

	// ----------------------------------------------------------------
	// ring and erase procedure
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			wp_q    <= 3'h0;
			count_q <= 4'h0;
			busy_q  <= 1'b0;
			ci_q    <= 3'h0;
		end else if (busy_q) begin
			mem_q[ci_q] <= '0;
			ci_q        <= 3'(ci_q + 3'h1);
			if (ci_q == 3'(DEPTH - 1)) begin
				busy_q  <= 1'b0;
				wp_q    <= 3'h0;
				count_q <= 4'h0;
			end
		end else if (hist.clr) begin
			busy_q <= 1'b1;
			ci_q   <= 3'h0;
		end else if (hist.wr) begin
			mem_q[wp_q] <= hist.wdata;
			wp_q        <= 3'(wp_q + 3'h1);
			if (count_q != 4'(DEPTH))
				count_q <= 4'(count_q + 4'h1);
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	count_cap_a: assert property (count_q <= 4'(DEPTH))
		else $error("history count above depth");
	erase_done_a: assert property ($rose(busy_q) |-> ##[8:9] (!busy_q && count_q == 4'h0))
		else $error("history erase did not finish empty");
endmodule : bcm_trip_store
`default_nettype wire

// ===== pkg/bcm_hist_if.sv
/*
 * carrier between the monitor and its trip history store.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface bcm_hist_if;
	logic             wr;
	bcm_pkg::bcm_rec_s wdata;
	logic             clr;
	logic             busy;
	logic [2:0]       rd_ofs;
	bcm_pkg::bcm_rec_s rdata;
	logic [3:0]       count;

	modport store (input wr, wdata, clr, rd_ofs, output busy, rdata, count);
	modport ctl   (output wr, wdata, clr, rd_ofs, input busy, rdata, count);
endinterface : bcm_hist_if
`default_nettype wire

// ===== pkg/bcm_pkg.sv
/*
 * constants, types and record layout of the breaker clearing time monitor.
 * assumes a 100 mhz processing clock shared by the trip unit logic.
 */
package bcm_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS    = 10;
	localparam int unsigned TICK_US          = 10;
	localparam int unsigned TICK_CYC         = TICK_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned SLOW_LIMIT_MS    = 33;
	localparam logic [15:0] SLOW_LIMIT_TICKS = 16'(SLOW_LIMIT_MS * 1000 / TICK_US);
	localparam logic [15:0] TIME_MAX         = 16'hffff;
	localparam int unsigned NREC             = 8;
	localparam int unsigned NPOLE            = 3;
	localparam int unsigned NFAULT           = 6;
	localparam logic [15:0] CNT_RESET        = 16'h0000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0][15:0] cur;   // phase a, b, c, neutral, ground fault
		logic [31:0]      stamp; // time of day and date
		logic [2:0][15:0] ctime; // clearing time per pole, 10 us ticks
	} bcm_rec_s;

	typedef enum logic [1:0] {
		TM_IDLE   = 2'b00,
		TM_TIMING = 2'b01,
		TM_STORE  = 2'b11
	} bcm_tstate_e;

	typedef enum logic [1:0] {
		VW_MAIN  = 2'b00,
		VW_ALARM = 2'b01,
		VW_OTHER = 2'b11,
		VW_HIST  = 2'b10
	} bcm_view_e;
endpackage : bcm_pkg

// ===== verification/bcm_breaker_model.sv
/*
 * breaker model: actuator and position switch on the far side of the monitor.
 * assumes trip, open and close requests arrive on clk_in; delays count cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module bcm_breaker_model (
	input  wire logic             clk_in,
	input  wire logic             resetn_in,
	input  wire logic             trip_in,
	input  wire logic             open_in,
	input  wire logic             close_in,
	input  wire logic [2:0][15:0] delay_in,
	output logic      [2:0]       pole_zero_out,
	output logic                  limit_sw_out
);
	logic        run_q;
	logic [15:0] cnt_q;

	// poles part one by one; the switch flips when pole a has gone
	always_ff @(posedge clk_in) begin
		if (!resetn_in || close_in) begin
			run_q <= 1'b0;
			cnt_q <= 16'h0000;
			pole_zero_out <= 3'h0;
			limit_sw_out <= 1'b0;
		end else if (open_in) begin
			pole_zero_out <= 3'h7;
			limit_sw_out <= 1'b1;
		end else if (trip_in && !run_q) begin
			run_q <= 1'b1;
			cnt_q <= 16'h0000;
		end else if (run_q) begin
			cnt_q <= cnt_q + 16'h0001;
			for (int i = 0; i < 3; i++) begin
				if (cnt_q >= delay_in[i]) begin
					pole_zero_out[i] <= 1'b1;
				end
			end
			if (cnt_q >= delay_in[0]) begin
				limit_sw_out <= 1'b1;
			end
		end
	end
endmodule : bcm_breaker_model
`default_nettype wire

// ===== verification/bcm_monitor_tb_top.sv
/*
 * self-checking bench of the clearing time monitor with a breaker model.
 * assumes a tick of 2 cycles, so the slow limit sits at 6600 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module bcm_monitor_tb_top;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic                  clk_in = 0, resetn_in = 0, trip_pulse_in = 0, method_limit_in = 0;
	logic                  fv_on_slow_in = 0, other_alarm_in = 0, open = 0, close = 0;
	logic [7:0]            btn = '0;
	logic [5:0]            fault_in = '0;
	logic [4:0][15:0]      cur_in = '0;
	logic [31:0]           stamp_in = '0;
	logic [2:0][15:0]      dly = '0;
	logic [2:0]            pole_zero_in, rec_ofs_out;
	logic                  limit_sw_in, relay, slow_alarm_out, timing_out, hist_busy_out, health_ok_out;
	logic [1:0]            view_out;
	logic [4:0][15:0]      rec_cur_out;
	logic [31:0]           rec_stamp_out;
	logic [2:0][15:0]      rec_time_out;
	logic [3:0]            hist_count_out;
	int                    num_errors = 0, num_checks = 0, cycles = 0;

	always #5 clk_in = ~clk_in;

	bcm_monitor #(.TICK_CYC(2)) uut (.clk_in(clk_in), .resetn_in(resetn_in), .trip_pulse_in(trip_pulse_in),
		.method_limit_in(method_limit_in), .pole_zero_in(pole_zero_in), .limit_sw_in(limit_sw_in),
		.cur_in(cur_in), .stamp_in(stamp_in), .fv_on_slow_in(fv_on_slow_in), .relay_release_in(btn[7]),
		.display_req_in(btn[0]), .clear_alarm_in(btn[1]), .next_in(btn[2]), .other_alarm_in(other_alarm_in),
		.review_in(btn[3]), .prev_in(btn[4]), .exit_in(btn[5]), .clear_hist_in(btn[6]), .fault_in(fault_in),
		.segregated_trip_relay_out(relay), .slow_alarm_out(slow_alarm_out), .view_out(view_out),
		.timing_out(timing_out), .rec_cur_out(rec_cur_out), .rec_stamp_out(rec_stamp_out),
		.rec_time_out(rec_time_out), .rec_ofs_out(rec_ofs_out), .hist_count_out(hist_count_out),
		.hist_busy_out(hist_busy_out), .health_ok_out(health_ok_out));

	bcm_breaker_model brk (.clk_in(clk_in), .resetn_in(resetn_in), .trip_in(trip_pulse_in), .open_in(open),
		.close_in(close), .delay_in(dly), .pole_zero_out(pole_zero_in), .limit_sw_out(limit_sw_in));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic finish_test;
		if (num_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test

	// ceiling well above the one slow trip of about 6700 cycles
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask : check

	// the tick count restarts on the trip pulse; times still get a margin of 3 ticks
	task automatic rng(input logic [15:0] got, input int exp);
		num_checks++;
		if ((^got === 1'bx) || got + 3 < exp || got > exp + 3) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp[15:0]);
			num_errors++;
		end
	endtask : rng

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : cyc

	task automatic press(input int b);
		btn[b] = 1'b1;
		cyc(1);
		btn = '0;
		cyc(3);
	endtask : press

	task automatic trip(input logic lim, input int d, input logic [31:0] st, input logic [3:0] n);
		int k;
		method_limit_in = lim;
		dly = {16'(d + 20), 16'(d + 10), 16'(d)};
		stamp_in = st;
		for (k = 0; k < 5; k++) cur_in[k] = {4'(k), st[11:0]};
		trip_pulse_in = 1'b1;
		cyc(1);
		trip_pulse_in = 1'b0;
		cyc(2);
		check(timing_out, 1'b1);
		for (k = 0; k < d + 200 && timing_out !== 1'b0; k++) cyc(1);
		cyc(8);
		check(hist_count_out, n);
		close = 1'b1;
		cyc(1);
		close = 1'b0;
	endtask : trip

	task automatic rec_chk(input logic [2:0] ofs, input logic [31:0] st);
		check(rec_ofs_out, ofs);
		check(rec_stamp_out, st);
		for (int k = 0; k < 5; k++) check(rec_cur_out[k], {4'(k), st[11:0]});
	endtask : rec_chk

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_zero;
		fv_on_slow_in = 1'b1;
		trip(1'b0, 40, 32'h0000_0001, 4'h1);
		check(relay, 1'b0);
		press(0);
		check(view_out, bcm_pkg::VW_MAIN);
		press(3);
		cyc(2);
		rec_chk(3'h0, 32'h0000_0001);
		for (int i = 0; i < 3; i++) rng(rec_time_out[i], (40 + 10 * i) / 2);
		press(5);
	endtask : t_zero

	task automatic t_limit;
		trip(1'b1, 60, 32'h0000_0002, 4'h2);
		press(3);
		cyc(2);
		rng(rec_time_out[0], 31);
		check(rec_time_out[2:1], 32'h0);
		press(5);
	endtask : t_limit

	task automatic t_other;
		open = 1'b1;
		cyc(1);
		open = 1'b0;
		cyc(20);
		check(timing_out, 1'b0);
		check(hist_count_out, 4'h2);
		close = 1'b1;
		cyc(1);
		close = 1'b0;
	endtask : t_other

	task automatic t_slow;
		trip(1'b0, 6700, 32'h0000_0003, 4'h3);
		check(relay, 1'b1);
		check(slow_alarm_out, 1'b0);
		press(1);
		press(0);
		check(view_out, bcm_pkg::VW_ALARM);
		check(slow_alarm_out, 1'b1);
		other_alarm_in = 1'b1;
		press(2);
		check(view_out, bcm_pkg::VW_OTHER);
		press(2);
		check(view_out, bcm_pkg::VW_MAIN);
		press(0);
		check(view_out, bcm_pkg::VW_ALARM);
		other_alarm_in = 1'b0;
		press(2);
		check(view_out, bcm_pkg::VW_MAIN);
		press(0);
		check(view_out, bcm_pkg::VW_ALARM);
		press(1);
		check(view_out, bcm_pkg::VW_MAIN);
		check(slow_alarm_out, 1'b0);
		press(0);
		check(view_out, bcm_pkg::VW_MAIN);
		press(7);
		check(relay, 1'b0);
	endtask : t_slow

	task automatic t_hist;
		int m;
		for (int s = 4; s < 10; s++) trip(1'b0, 20, 32'(s), (s > 8) ? 4'h8 : 4'(s));
		press(3);
		cyc(2);
		rec_chk(3'h0, 32'h0000_0009);
		for (int k = 1; k < 9; k++) begin
			press(4);
			cyc(2);
			m = (k > 7) ? 7 : k;
			rec_chk(3'(m), 32'(9 - m));
		end
		press(5);
	endtask : t_hist

	task automatic t_erase;
		press(6);
		check(hist_busy_out, 1'b1);
		cyc(12);
		check(hist_count_out, 4'h0);
		check(hist_busy_out, 1'b0);
		press(3);
		check(view_out, bcm_pkg::VW_MAIN);
	endtask : t_erase

	task automatic t_health;
		for (int b = 0; b < 6; b++) begin
			fault_in = 6'(1 << b);
			cyc(3);
			check(health_ok_out, 1'b0);
			fault_in = '0;
			cyc(4);
			check(health_ok_out, 1'b1);
		end
	endtask : t_health

	initial begin
		cyc(3);
		check(health_ok_out, 1'b0);
		resetn_in = 1'b1;
		cyc(4);
		check(health_ok_out, 1'b1);
		check(view_out, bcm_pkg::VW_MAIN);
		t_zero();
		t_limit();
		t_other();
		t_slow();
		t_hist();
		t_erase();
		t_health();
		finish_test();
	end
endmodule : bcm_monitor_tb_top
`default_nettype wire
